// [core/hpp_dev_end.sv]
// Device end of the host parallel port
`default_nettype none
module hpp_dev_end
  import hpp_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  hpp_link_if.dev lnk,
  input wire logic [1:0] pin_mode,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  output logic dma_req_valid,
  output logic dma_req_write,
  output logic [31:0] dma_req_addr,
  output logic [31:0] dma_req_wdata,
  input wire logic dma_req_ready,
  input wire logic dma_rsp_valid,
  input wire logic [31:0] dma_rsp_data,
  output logic port_owned
);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(BUF_DEPTH);
  if (BUF_DEPTH < 2 || (1 << PW) != BUF_DEPTH) begin : g_chk
    $error("BUF_DEPTH must be a power of two, at least 2");
  end

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DMA = 2'b01,
    S_FULL = 2'b10,
    S_RDY = 2'b11
  } hpp_dstate_t;

  hpp_dstate_t st_q, st_d;
  logic stb_prev_q, as_prev_q, as_seen_q, as_seen_d;
  logic [2:0] cap_q, cap_d;
  hpp_sel_t sel_q, sel_d;
  logic rd_q, rd_d, hw_q, hw_d, rdpend_q, rdpend_d;
  logic [31:0] ctrl_q, ctrl_d, waddr_q, waddr_d, raddr_q, raddr_d, trctl_q, trctl_d;
  logic [31:0] data_q, data_d, hd_last_q;
  logic [15:0] half_q, half_d;
  logic rdy_n_q, rdy_n_d, oe_q, oe_d, ack_q, ack_d, own_q;
  logic [31:0] hdo_q, hdo_d, crd_q, crd_d;
  logic rv_q, rv_d, rw_q, rw_d;
  logic [31:0] ra_q, ra_d, rwd_q, rwd_d;
  logic [31:0] bad_q [BUF_DEPTH];
  logic [31:0] bdat_q [BUF_DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  logic strb_n, fall, rise, as_fall, en, m16, full, push, pop, hi1st;
  logic [2:0] lsel;
  logic [31:0] word_in, rsrc;

  // ----------------------------------------
  // Strobe decode and select capture
  // ----------------------------------------
  always_comb begin
    strb_n = lnk.host_chip_select_n |
             ~(lnk.host_data_strobe_a ^ lnk.host_data_strobe_b);
    fall = stb_prev_q & ~strb_n;
    rise = ~stb_prev_q & strb_n;
    as_fall = as_prev_q & ~lnk.host_address_strobe_n;
    en = (pin_mode == PM_HOST32) || (pin_mode == PM_HOST16);
    m16 = (pin_mode == PM_HOST16);
    full = (cnt_q == FULL_CNT);
    hi1st = ctrl_q[CTRL_HI_FIRST];
    // Selects from the address strobe if pulsed, else from the strobe
    lsel = as_seen_q ? cap_q : {lnk.host_register_select, lnk.host_read_write_select};
    cap_d = as_fall ? {lnk.host_register_select, lnk.host_read_write_select} : cap_q;
    as_seen_d = rise ? 1'b0 : (as_fall | as_seen_q);
  end

  // ----------------------------------------
  // Access sequencer and registers
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    sel_d = sel_q;
    rd_d = rd_q;
    hw_d = hw_q;
    rdpend_d = rdpend_q;
    ctrl_d = ctrl_q;
    waddr_d = waddr_q;
    raddr_d = raddr_q;
    trctl_d = trctl_q;
    data_d = data_q;
    half_d = half_q;
    push = 1'b0;
    ack_d = cpu_req;
    crd_d = crd_q;
    word_in = hi1st ? {half_q, hd_last_q[15:0]} : {hd_last_q[15:0], half_q};
    if (!m16) word_in = hd_last_q;
    // CPU side: data register has no address here
    if (cpu_req) begin
      unique case (cpu_addr)
        OFS_CTRL: crd_d = ctrl_q;
        OFS_WADDR: crd_d = waddr_q;
        OFS_RADDR: crd_d = raddr_q;
        OFS_TRCTL: crd_d = trctl_q;
        default: crd_d = ZERO_WORD;
      endcase
      if (cpu_we) begin
        if (cpu_addr == OFS_CTRL) ctrl_d = cpu_wdata;
        if (cpu_addr == OFS_WADDR) waddr_d = cpu_wdata;
        if (cpu_addr == OFS_RADDR) raddr_d = cpu_wdata;
        if (cpu_addr == OFS_TRCTL) trctl_d = cpu_wdata;
      end
    end
    unique case (st_q)
      S_IDLE: begin
        if (fall && en) begin
          sel_d = hpp_sel_t'(lsel[2:1]);
          rd_d = lsel[0];
          hw_d = m16 & lnk.host_half_word_select;
          st_d = S_RDY;
          if (lsel[2]) begin
            if (lsel[0] && !(m16 && lnk.host_half_word_select)) begin
              rdpend_d = 1'b1;
              st_d = S_DMA;
            end else if (!lsel[0] && full) begin
              st_d = S_FULL;
            end
          end
        end
      end
      S_DMA: if (dma_rsp_valid) begin
        data_d = dma_rsp_data;
        st_d = S_RDY;
      end
      S_FULL: if (!full) st_d = S_RDY;
      S_RDY: if (rise) begin
        st_d = S_IDLE;
        if (!rd_q && m16 && !hw_q) begin
          half_d = hd_last_q[15:0];
        end else if (!rd_q) begin
          unique case (sel_q)
            SEL_CTRL: ctrl_d = word_in;
            SEL_ADDR: begin
              waddr_d = word_in;
              raddr_d = word_in;
            end
            SEL_DATA_INC, SEL_DATA_FIX: begin
              data_d = word_in;
              push = 1'b1;
              if (sel_q == SEL_DATA_INC) waddr_d = waddr_q + ADDR_STEP;
            end
          endcase
        end else if (sel_q == SEL_DATA_INC && (!m16 || hw_q)) begin
          raddr_d = raddr_q + ADDR_STEP;
        end
      end
    endcase
    if (rdpend_q && !(cnt_q != '0) && (!rv_q || dma_req_ready)) rdpend_d = 1'b0;
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_comb begin
    // Next-state view, so the word stands on the bus when ready falls
    unique case (sel_d)
      SEL_CTRL: rsrc = ctrl_d;
      SEL_ADDR: rsrc = waddr_d;
      default: rsrc = data_d;
    endcase
    hdo_d = rsrc;
    if (m16) begin
      hdo_d = {16'h0000, (hw_d ^ hi1st) ? rsrc[31:16] : rsrc[15:0]};
    end
    rdy_n_d = ~(st_d == S_RDY) | rise;
    oe_d = (st_d == S_RDY) & rd_d & ~strb_n;
  end

  // ----------------------------------------
  // Write buffer and DMA request register
  // ----------------------------------------
  always_comb begin
    rv_d = rv_q;
    rw_d = rw_q;
    ra_d = ra_q;
    rwd_d = rwd_q;
    pop = 1'b0;
    if (!rv_q || dma_req_ready) begin
      rv_d = 1'b0;
      if (cnt_q != '0) begin
        rv_d = 1'b1;
        rw_d = 1'b1;
        ra_d = bad_q[rp_q];
        rwd_d = bdat_q[rp_q];
        pop = 1'b1;
      end else if (rdpend_q) begin
        rv_d = 1'b1;
        rw_d = 1'b0;
        ra_d = raddr_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      bad_q[wp_q] <= waddr_q;
      bdat_q[wp_q] <= word_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      stb_prev_q <= 1'b1;
      as_prev_q <= 1'b1;
      as_seen_q <= 1'b0;
      cap_q <= 3'h0;
      sel_q <= SEL_CTRL;
      rd_q <= 1'b0;
      hw_q <= 1'b0;
      rdpend_q <= 1'b0;
      ctrl_q <= RST_CTRL;
      waddr_q <= RST_ADDR;
      raddr_q <= RST_ADDR;
      trctl_q <= RST_TRCTL;
      data_q <= ZERO_WORD;
      hd_last_q <= ZERO_WORD;
      half_q <= 16'h0000;
      rdy_n_q <= 1'b1;
      oe_q <= 1'b0;
      hdo_q <= ZERO_WORD;
      ack_q <= 1'b0;
      crd_q <= ZERO_WORD;
      own_q <= 1'b0;
      rv_q <= 1'b0;
      rw_q <= 1'b0;
      ra_q <= ZERO_WORD;
      rwd_q <= ZERO_WORD;
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      stb_prev_q <= strb_n;
      as_prev_q <= lnk.host_address_strobe_n;
      as_seen_q <= as_seen_d;
      cap_q <= cap_d;
      sel_q <= sel_d;
      rd_q <= rd_d;
      hw_q <= hw_d;
      rdpend_q <= rdpend_d;
      ctrl_q <= ctrl_d;
      waddr_q <= waddr_d;
      raddr_q <= raddr_d;
      trctl_q <= trctl_d;
      data_q <= data_d;
      hd_last_q <= strb_n ? hd_last_q : lnk.host_data_bus;
      half_q <= half_d;
      rdy_n_q <= rdy_n_d;
      oe_q <= oe_d;
      hdo_q <= hdo_d;
      ack_q <= ack_d;
      crd_q <= crd_d;
      own_q <= en;
      rv_q <= rv_d;
      rw_q <= rw_d;
      ra_q <= ra_d;
      rwd_q <= rwd_d;
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  assign lnk.host_ready_n = rdy_n_q;
  assign lnk.host_data_bus_dev_o = hdo_q;
  assign lnk.host_data_bus_dev_oe = oe_q;
  assign cpu_ack = ack_q;
  assign cpu_rdata = crd_q;
  assign dma_req_valid = rv_q;
  assign dma_req_write = rw_q;
  assign dma_req_addr = ra_q;
  assign dma_req_wdata = rwd_q;
  assign port_owned = own_q;
endmodule : hpp_dev_end
`default_nettype wire

// [core/hpp_host_end.sv]
// Host end of the host parallel port
`default_nettype none
module hpp_host_end
  import hpp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  hpp_link_if.host lnk,
  input wire logic mode16,
  input wire logic use_as,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_sel,
  input wire logic cmd_read,
  input wire logic [31:0] cmd_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_LOW = 2'b10,
    H_GAP = 2'b11
  } hpp_hstate_t;
  localparam logic [3:0] LOW_LAST = 4'(HOST_LOW_CYC - 1);
  localparam logic [3:0] GAP_LAST = 4'(STB_HIGH_CYC - 1);

  hpp_hstate_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic half_q, half_d, rd_q, rd_d, rdy_q, rdy_d, rv_q, rv_d;
  logic cs_n_q, cs_n_d, dsb_q, dsb_d, as_n_q, as_n_d, oe_q, oe_d;
  logic [1:0] sel_q, sel_d;
  logic [31:0] wd_q, wd_d, rdat_q, rdat_d, hdo_q, hdo_d;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    half_d = half_q;
    rd_d = rd_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    cs_n_d = cs_n_q;
    dsb_d = dsb_q;
    as_n_d = 1'b1;
    oe_d = oe_q;
    sel_d = sel_q;
    wd_d = wd_q;
    rdat_d = rdat_q;
    unique case (st_q)
      H_IDLE: if (cmd_valid) begin
        rdy_d = 1'b0;
        sel_d = cmd_sel;
        rd_d = cmd_read;
        wd_d = cmd_wdata;
        half_d = 1'b0;
        cs_n_d = 1'b0;
        oe_d = ~cmd_read;
        as_n_d = ~use_as;
        st_d = H_SETUP;
      end
      H_SETUP: begin
        dsb_d = 1'b1;
        cnt_d = 4'h0;
        st_d = H_LOW;
      end
      H_LOW: begin
        if (cnt_q != LOW_LAST) cnt_d = cnt_q + 4'h1;
        if (cnt_q == LOW_LAST && !lnk.host_ready_n) begin
          dsb_d = 1'b0;
          cnt_d = 4'h0;
          st_d = H_GAP;
          if (!mode16) rdat_d = lnk.host_data_bus;
          else if (!half_q) rdat_d[15:0] = lnk.host_data_bus[15:0];
          else rdat_d[31:16] = lnk.host_data_bus[15:0];
        end
      end
      H_GAP: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == GAP_LAST) begin
          if (mode16 && !half_q) begin
            half_d = 1'b1;
            as_n_d = ~use_as;
            st_d = H_SETUP;
          end else begin
            cs_n_d = 1'b1;
            oe_d = 1'b0;
            rv_d = 1'b1;
            rdy_d = 1'b1;
            st_d = H_IDLE;
          end
        end
      end
    endcase
    hdo_d = mode16 ? {16'h0000, half_d ? wd_d[31:16] : wd_d[15:0]} : wd_d;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= H_IDLE;
      cnt_q <= 4'h0;
      half_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b1;
      rv_q <= 1'b0;
      cs_n_q <= 1'b1;
      dsb_q <= 1'b0;
      as_n_q <= 1'b1;
      oe_q <= 1'b0;
      sel_q <= 2'h0;
      wd_q <= ZERO_WORD;
      hdo_q <= ZERO_WORD;
      rdat_q <= ZERO_WORD;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      cs_n_q <= cs_n_d;
      dsb_q <= dsb_d;
      as_n_q <= as_n_d;
      oe_q <= oe_d;
      sel_q <= sel_d;
      wd_q <= wd_d;
      hdo_q <= hdo_d;
      rdat_q <= rdat_d;
    end
  end

  assign lnk.host_chip_select_n = cs_n_q;
  assign lnk.host_data_strobe_a = 1'b0;
  assign lnk.host_data_strobe_b = dsb_q;
  assign lnk.host_address_strobe_n = as_n_q;
  assign lnk.host_register_select = sel_q;
  assign lnk.host_read_write_select = rd_q;
  assign lnk.host_half_word_select = half_q;
  assign lnk.host_data_bus_host_o = hdo_q;
  assign lnk.host_data_bus_host_oe = oe_q;
  assign cmd_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
endmodule : hpp_host_end
`default_nettype wire

// [core/hpp_link_if.sv]
// Pin-level link between host and device ends
`default_nettype none
interface hpp_link_if;
  logic host_chip_select_n;
  logic host_data_strobe_a;
  logic host_data_strobe_b;
  logic host_address_strobe_n;
  logic [1:0] host_register_select;
  logic host_read_write_select;
  logic host_half_word_select;
  logic host_ready_n;
  logic [31:0] host_data_bus_dev_o;
  logic host_data_bus_dev_oe;
  logic [31:0] host_data_bus_host_o;
  logic host_data_bus_host_oe;
  logic [31:0] host_data_bus;
  // Resolved bus level, undriven reads as zero
  assign host_data_bus = host_data_bus_dev_oe ? host_data_bus_dev_o :
                         host_data_bus_host_oe ? host_data_bus_host_o : 32'h0000_0000;
  modport dev (
    input host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    input host_address_strobe_n, host_register_select, host_read_write_select,
    input host_half_word_select, host_data_bus,
    output host_ready_n, host_data_bus_dev_o, host_data_bus_dev_oe
  );
  modport host (
    output host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    output host_address_strobe_n, host_register_select, host_read_write_select,
    output host_half_word_select, host_data_bus_host_o, host_data_bus_host_oe,
    input host_ready_n, host_data_bus
  );
endinterface : hpp_link_if
`default_nettype wire

// [core/hpp_pkg.sv]
// Shared constants and types of the host parallel port
`default_nettype none
package hpp_pkg;
  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam logic [31:0] OFS_CTRL = 32'h0188_0000;
  localparam logic [31:0] OFS_WADDR = 32'h0188_0004;
  localparam logic [31:0] OFS_RADDR = 32'h0188_0008;
  localparam logic [31:0] OFS_TRCTL = 32'h018A_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_TRCTL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Control bit: first half-word carries the upper half
  localparam int CTRL_HI_FIRST = 0;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_ADDR = 2'b01,
    SEL_DATA_INC = 2'b10,
    SEL_DATA_FIX = 2'b11
  } hpp_sel_t;
  localparam logic [1:0] PM_PCI = 2'h0;
  localparam logic [1:0] PM_HOST32 = 2'h1;
  localparam logic [1:0] PM_HOST16 = 2'h2;
  // ----------------------------------------
  // Timing, clock 20 MHz
  // ----------------------------------------
  localparam int CLK_PS = 50000;
  localparam int STB_PERIODS = 4;
  localparam int STB_LOW_MIN_PS = 12500;
  localparam int RD2_EXTRA_PS = 8000;
  localparam int STB_LOW_NS_CYC = (STB_LOW_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int STB_LOW_CYC = (STB_LOW_NS_CYC > STB_PERIODS) ? STB_LOW_NS_CYC : STB_PERIODS;
  localparam int STB_HIGH_CYC = STB_PERIODS;
  localparam int RD2_CYC = (STB_PERIODS * CLK_PS + RD2_EXTRA_PS) / CLK_PS;
  localparam int HOST_LOW_CYC = (RD2_CYC > STB_LOW_CYC) ? RD2_CYC : STB_LOW_CYC;
endpackage : hpp_pkg
`default_nettype wire

// [dv/host_parallel_port_bench.sv]
// Self-checking bench joining the host and device ends
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module host_parallel_port_bench import hpp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, cpu_req, cpu_we, cpu_ack, port_owned, mode16, use_as;
  logic dma_req_valid, dma_req_write, dma_req_ready, dma_rsp_valid;
  logic cmd_valid, cmd_ready, cmd_read, rsp_valid, stall, rd_pend;
  logic [1:0] pin_mode, cmd_sel;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, dma_req_addr, dma_req_wdata, dma_rsp_data;
  logic [31:0] cmd_wdata, rsp_rdata, rd_addr, r;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] exp_mem [logic [31:0]];
  logic [31:0] vals [5];
  logic [31:0] offs [5] = '{OFS_CTRL, OFS_WADDR, OFS_RADDR, OFS_TRCTL, 32'h0188_000C};
  int mismatches, checks_done, seed, rsp_cnt;
  hpp_link_if u_lnk ();
  hpp_dev_end u_hpp_dev_end (.mclk, .rst_b, .lnk(u_lnk), .pin_mode, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_rdata, .dma_req_valid, .dma_req_write,
    .dma_req_addr, .dma_req_wdata, .dma_req_ready, .dma_rsp_valid, .dma_rsp_data,
    .port_owned);
  hpp_host_end u_hpp_host_end (.mclk, .rst_b, .lnk(u_lnk), .mode16, .use_as, .cmd_valid,
    .cmd_ready, .cmd_sel, .cmd_read, .cmd_wdata, .rsp_valid, .rsp_rdata);
  hpp_link_sva u_hpp_link_sva (.mclk, .rst_b,
    .host_chip_select_n(u_lnk.host_chip_select_n),
    .host_data_strobe_a(u_lnk.host_data_strobe_a),
    .host_data_strobe_b(u_lnk.host_data_strobe_b),
    .host_address_strobe_n(u_lnk.host_address_strobe_n),
    .host_register_select(u_lnk.host_register_select),
    .host_read_write_select(u_lnk.host_read_write_select),
    .host_ready_n(u_lnk.host_ready_n),
    .host_data_bus_dev_oe(u_lnk.host_data_bus_dev_oe),
    .host_data_bus_host_oe(u_lnk.host_data_bus_host_oe));
  always #25 mclk = !mclk;
  always @(posedge mclk) if (rsp_valid === 1'b1) rsp_cnt++;
  // ----------------------------------------
  // Memory behind the DMA generator
  // ----------------------------------------
  always @(posedge mclk) begin
    if (dma_req_valid === 1'b1 && dma_req_ready) begin
      if (dma_req_write) mem[dma_req_addr] = dma_req_wdata;
      else begin
        rd_pend = 1;
        rd_addr = dma_req_addr;
      end
    end
  end
  // Random stalls and latency; idle data is noise
  always @(negedge mclk) begin
    r = $random(seed);
    dma_req_ready = !stall && r[0];
    if (rd_pend && r[2:1] == 2'h0) begin
      dma_rsp_valid = 1;
      dma_rsp_data = mem[rd_addr];
      rd_pend = 0;
    end else begin
      dma_rsp_valid = 0;
      dma_rsp_data = r;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic hang;
    mismatches++;
    end_sim();
  endtask : hang
  task automatic cpu(input logic we, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    cpu_req = 1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge mclk);
    cpu_req = 0;
    `CHK("cpu_ack", 1'b1, cpu_ack)
    q = cpu_rdata;
    @(negedge mclk);
  endtask : cpu
  task automatic host(input logic [1:0] s, input logic rd, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    cmd_valid = 1;
    cmd_sel = s;
    cmd_read = rd;
    cmd_wdata = d;
    for (n = 0; cmd_ready !== 1'b1; n++) begin
      if (n > 600) hang();
      @(negedge mclk);
    end
    @(negedge mclk);
    cmd_valid = 0;
    for (n = 0; rsp_valid !== 1'b1; n++) begin
      if (n > 600) hang();
      @(negedge mclk);
    end
    q = rsp_rdata;
    @(negedge mclk);
  endtask : host
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q, v, b;
    int m, i, c0;
    mclk = 0;
    rst_b = 0;
    seed = 7690;
    {cpu_req, cpu_we, cmd_valid, cmd_read, stall, rd_pend, dma_req_ready, dma_rsp_valid} = '0;
    {cpu_addr, cpu_wdata, cmd_wdata, dma_rsp_data, cmd_sel, mode16, use_as} = '0;
    pin_mode = PM_HOST32;
    rsp_cnt = 0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1;
    @(negedge mclk);
    `CHK("port_owned", 1'b1, port_owned)
    for (i = 0; i < 5; i++) begin
      cpu(0, offs[i], ZERO_WORD, q);
      `CHK("reset value", ZERO_WORD, q)
    end
    for (i = 0; i < 5; i++) begin
      vals[i] = $random(seed);
      vals[i][CTRL_HI_FIRST] = 1'b0;
      cpu(1, offs[i], vals[i], q);
    end
    for (i = 0; i < 5; i++) begin
      cpu(0, offs[i], ZERO_WORD, q);
      `CHK("cpu readback", (i == 4) ? ZERO_WORD : vals[i], q)
    end
    for (m = 0; m < 4; m++) begin
      mode16 = m[1];
      use_as = m[0];
      pin_mode = m[1] ? PM_HOST16 : PM_HOST32;
      b = 32'h0000_1000 + (32'(m) << 8);
      host(SEL_ADDR, 0, b, q);
      cpu(0, OFS_WADDR, ZERO_WORD, q);
      `CHK("write address", b, q)
      cpu(0, OFS_RADDR, ZERO_WORD, q);
      `CHK("read address", b, q)
      host(SEL_CTRL, 1, ZERO_WORD, q);
      `CHK("host ctrl", vals[0], q)
      host(SEL_ADDR, 1, ZERO_WORD, q);
      `CHK("host address", b, q)
      stall = 1;
      c0 = rsp_cnt;
      fork
        for (i = 0; i < 4; i++) begin
          v = $random(seed);
          exp_mem[b + ADDR_STEP * 32'(i)] = v;
          host(SEL_DATA_INC, 0, v, q);
        end
        begin
          repeat (100) @(negedge mclk);
          `CHK("writes taken", 1'b1, ((rsp_cnt - c0) inside {[2:3]}))
          `CHK("ready held", 1'b1, u_lnk.host_ready_n)
          stall = 0;
        end
      join
      host(SEL_ADDR, 0, b, q);
      for (i = 0; i < 4; i++) begin
        host(SEL_DATA_INC, 1, ZERO_WORD, q);
        `CHK("read word", exp_mem[b + ADDR_STEP * 32'(i)], q)
      end
      host(SEL_ADDR, 0, b, q);
      v = $random(seed);
      exp_mem[b] = v;
      host(SEL_DATA_FIX, 0, v, q);
      host(SEL_DATA_FIX, 1, ZERO_WORD, q);
      `CHK("fixed read", v, q)
      host(SEL_DATA_FIX, 1, ZERO_WORD, q);
      `CHK("fixed reread", v, q)
      for (i = 0; i < 4; i++) begin
        v = b + ADDR_STEP * 32'(i);
        `CHK("dma word", exp_mem[v], mem[v])
      end
    end
    pin_mode = PM_PCI;
    repeat (2) @(negedge mclk);
    `CHK("port_owned", 1'b0, port_owned)
    end_sim();
  end
endmodule : host_parallel_port_bench
`default_nettype wire

// [dv/hpp_link_sva.sv]
// Protocol checks on the link between host and device ends
`default_nettype none
module hpp_link_sva (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic host_chip_select_n,
  input wire logic host_data_strobe_a,
  input wire logic host_data_strobe_b,
  input wire logic host_address_strobe_n,
  input wire logic [1:0] host_register_select,
  input wire logic host_read_write_select,
  input wire logic host_ready_n,
  input wire logic host_data_bus_dev_oe,
  input wire logic host_data_bus_host_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Combined strobe, active high here
  wire logic stb = !host_chip_select_n && (host_data_strobe_a ^ host_data_strobe_b);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ready_in_cycle_a: assert property (
    !host_ready_n |-> stb || $past(stb) || $past(stb, 2) || $past(stb, 3))
    else $error("ready low outside a strobe cycle");
  drive_on_read_a: assert property (
    host_data_bus_dev_oe |-> host_read_write_select && (stb || $past(stb) || $past(stb, 2)
      || $past(stb, 3))) else $error("device drives bus outside a read");
  one_driver_a: assert property (
    !(host_data_bus_dev_oe && host_data_bus_host_oe)) else $error("bus driven by both ends");
  strobe_low_min_a: assert property (
    $rose(stb) |-> stb [*4]) else $error("strobe low too short");
  strobe_high_min_a: assert property (
    $fell(stb) |-> !stb [*4]) else $error("strobe high too short");
  hold_to_ready_a: assert property (
    $fell(stb) |-> !$past(host_ready_n)) else $error("strobe released before ready");
  addr_strobe_once_a: assert property (
    !host_address_strobe_n |=> host_address_strobe_n [*8]) else $error("address strobe repeated");
  reg_ready_fast_a: assert property (
    $rose(stb) && !host_register_select[1] |-> ##[1:3] !host_ready_n)
    else $error("register access not answered");
endmodule : hpp_link_sva
`default_nettype wire
